// [hw/oct_offset_trim_bank.sv]
// Purpose: Offset trim register bank feeding the B and C converter cores
// Assumes: Calibration status, input selects and factory trims come from logic on clk_i
// Notes: Software access limits during calibration are reported, not enforced
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module oct_offset_trim_bank import oct_pkg::*; (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// Register port
	input wire oct_req_t req_i,
	output logic [DATA_W-1:0] rd_data_o,
	// Factory trims, core C input A first
	input wire logic [NUM_TRIM*TRIM_W-1:0] factory_trim_i,
	// Calibration status and core input selection
	input wire oct_cal_t cal_i,
	input wire oct_sel_t sel_i,
	// Applied corrections
	output logic [TRIM_W-1:0] core_c_offset_o,
	output logic [TRIM_W-1:0] core_b_offset_o,
	// Access advice for software
	output logic write_safe_o,
	output logic read_safe_o
);

	logic load_pending_q;
	logic [NUM_TRIM*REG_W-1:0] words;
	logic [TRIM_W-1:0] core_c_offset_d;
	logic [TRIM_W-1:0] core_b_offset_d;
	logic write_safe_d;
	logic read_safe_d;
	oct_dec_t wr_dec;
	oct_dec_t rd_dec;
	wire wr_hit;
	wire rd_hit;

	// Address decode for both strobes
	assign wr_dec = oct_decode(req_i.addr);
	assign rd_dec = oct_decode(req_i.addr);
	assign wr_hit = req_i.wr && wr_dec.hit;
	assign rd_hit = req_i.rd && rd_dec.hit;

	// Factory load happens on the first enabled edge after release, since reset may only load constants
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			load_pending_q <= 1'b1;
		end else if (ce_i) begin
			load_pending_q <= 1'b0;
		end
	end

	oct_trim_store u_store (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.load_i(load_pending_q),
		.factory_i(factory_trim_i),
		.wr_i(wr_hit),
		.wr_idx_i(wr_dec.idx),
		.wr_hi_i(wr_dec.hi),
		.wr_data_i(req_i.wdata),
		.rd_i(rd_hit),
		.rd_idx_i(rd_dec.idx),
		.rd_hi_i(rd_dec.hi),
		.rd_data_o(rd_data_o),
		.words_o(words)
	);

	// Each core takes only its own pair, picked by the input it samples; reserved bits dropped
	assign core_c_offset_d = sel_i.core_c_on_b
		? words[IDX_CORE_C_INPUT_B*REG_W + TRIM_LSB +: TRIM_W]
		: words[IDX_CORE_C_INPUT_A*REG_W + TRIM_LSB +: TRIM_W];
	assign core_b_offset_d = sel_i.core_b_on_b
		? words[IDX_CORE_B_INPUT_B*REG_W + TRIM_LSB +: TRIM_W]
		: words[IDX_CORE_B_INPUT_A*REG_W + TRIM_LSB +: TRIM_W];

	// Advice flags mirror the software access limits
	assign write_safe_d = !cal_i.fg_running
		&& !(cal_i.background_cal_enable && cal_i.background_offset_cal_enable);
	assign read_safe_d = (cal_i.offset_cal_enable && !cal_i.background_offset_cal_enable)
		? cal_i.foreground_cal_done
		: ((cal_i.background_cal_enable && cal_i.background_offset_cal_enable)
			? cal_i.cal_halted_flag
			: 1'b1);

	// Output flops; corrections lag the select by one cycle
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			core_c_offset_o <= TRIM_RESET[TRIM_MSB:TRIM_LSB];
			core_b_offset_o <= TRIM_RESET[TRIM_MSB:TRIM_LSB];
			write_safe_o <= 1'b0;
			read_safe_o <= 1'b0;
		end else if (ce_i) begin
			core_c_offset_o <= core_c_offset_d;
			core_b_offset_o <= core_b_offset_d;
			write_safe_o <= write_safe_d;
			read_safe_o <= read_safe_d;
		end
	end

endmodule
`default_nettype wire

// [hw/oct_pkg.sv]
// Purpose: Constants and carriers for the core offset trim register bank
// Assumes: Byte-wide register port, 25 MHz clock, asynchronous active-low reset
// Notes: Each trim register is a 16-bit pair of byte addresses, low byte at the even one
// Behaviour
// - Each trim register holds a 12-bit unsigned correction in its low bits.
// - A trim value reaches only its own core and only while that core samples the matching input.
// - After reset each trim register holds the factory offset, readable and overwritable by software.
// - Core C input B trim sits at byte addresses 0x090-0x091.
// - Core B input A trim sits at byte addresses 0x092-0x093.
// - Core B input B trim sits at byte addresses 0x094-0x095.
// - Core C input A trim sits at byte addresses 0x08E-0x08F.
package oct_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned TRIM_W = 12;
	localparam int unsigned REG_W = 16;
	localparam int unsigned NUM_TRIM = 4;

	// Byte addresses of the low byte of each trim register, and of the last mapped byte
	localparam logic [ADDR_W-1:0] OFS_CORE_C_INPUT_A = 12'h08E;
	localparam logic [ADDR_W-1:0] OFS_CORE_C_INPUT_B = 12'h090;
	localparam logic [ADDR_W-1:0] OFS_CORE_B_INPUT_A = 12'h092;
	localparam logic [ADDR_W-1:0] OFS_CORE_B_INPUT_B = 12'h094;
	localparam logic [ADDR_W-1:0] OFS_LAST_BYTE = 12'h095;

	// Storage index of each register
	localparam logic [1:0] IDX_CORE_C_INPUT_A = 2'h0;
	localparam logic [1:0] IDX_CORE_C_INPUT_B = 2'h1;
	localparam logic [1:0] IDX_CORE_B_INPUT_A = 2'h2;
	localparam logic [1:0] IDX_CORE_B_INPUT_B = 2'h3;

	// Field layout
	localparam int unsigned TRIM_LSB = 0;
	localparam int unsigned TRIM_MSB = 11;
	localparam int unsigned RSVD_LSB = 12;
	localparam int unsigned RSVD_MSB = 15;
	localparam logic [3:0] RSVD_RESET = 4'h0;
	localparam logic [REG_W-1:0] TRIM_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;

	// Register port request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} oct_req_t;

	// Calibration engine status
	typedef struct packed {
		logic fg_running;
		logic background_cal_enable;
		logic background_offset_cal_enable;
		logic offset_cal_enable;
		logic foreground_cal_done;
		logic cal_halted_flag;
	} oct_cal_t;

	// Which input each core samples: 0 for input A, 1 for input B
	typedef struct packed {
		logic core_c_on_b;
		logic core_b_on_b;
	} oct_sel_t;

	// Decoded byte address
	typedef struct packed {
		logic hit;
		logic [1:0] idx;
		logic hi;
	} oct_dec_t;

	// Maps a byte address onto register index and byte lane
	function automatic oct_dec_t oct_decode(input logic [ADDR_W-1:0] addr);
		oct_dec_t d;
		logic [ADDR_W-1:0] rel;
		rel = addr - OFS_CORE_C_INPUT_A;
		d.hit = (addr >= OFS_CORE_C_INPUT_A) && (addr <= OFS_LAST_BYTE);
		d.idx = rel[2:1];
		d.hi = rel[0];
		return d;
	endfunction

endpackage

// [hw/oct_trim_store.sv]
// Purpose: Storage for the four trim words with a registered byte read port
// Assumes: Writes and loads come from logic on the same clock
// Notes: Factory load wins over a software write in the same cycle
`timescale 1ns/1ps
`default_nettype none
module oct_trim_store import oct_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// Factory load
	input wire logic load_i,
	input wire logic [NUM_TRIM*TRIM_W-1:0] factory_i,
	// Byte write
	input wire logic wr_i,
	input wire logic [1:0] wr_idx_i,
	input wire logic wr_hi_i,
	input wire logic [DATA_W-1:0] wr_data_i,
	// Byte read
	input wire logic rd_i,
	input wire logic [1:0] rd_idx_i,
	input wire logic rd_hi_i,
	output logic [DATA_W-1:0] rd_data_o,
	// Stored words
	output logic [NUM_TRIM*REG_W-1:0] words_o
);

	logic [REG_W-1:0] mem_q [NUM_TRIM];
	logic [REG_W-1:0] rd_word;

	assign rd_word = mem_q[rd_idx_i];

	// Word storage; reserved nibble clears on the factory load too
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < NUM_TRIM; i++) begin
				mem_q[i] <= TRIM_RESET;
			end
		end else if (ce_i) begin
			if (load_i) begin
				for (int i = 0; i < NUM_TRIM; i++) begin
					mem_q[i] <= {RSVD_RESET, factory_i[i*TRIM_W +: TRIM_W]};
				end
			end else if (wr_i) begin
				if (wr_hi_i) begin
					mem_q[wr_idx_i][RSVD_MSB:DATA_W] <= wr_data_i;
				end else begin
					mem_q[wr_idx_i][DATA_W-1:0] <= wr_data_i;
				end
			end
		end
	end

	// Read data live one cycle only, idle value otherwise
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_data_o <= RDATA_IDLE;
		end else if (ce_i) begin
			if (rd_i) begin
				rd_data_o <= rd_hi_i ? rd_word[RSVD_MSB:DATA_W] : rd_word[DATA_W-1:0];
			end else begin
				rd_data_o <= RDATA_IDLE;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_TRIM; g++) begin : g_out
			assign words_o[g*REG_W +: REG_W] = mem_q[g];
		end
	endgenerate

endmodule
`default_nettype wire

// [testbench/oct_sva.sv]
// Purpose: Port checks for the offset trim bank
// Assumes: One clock, ce_i mostly high
// Notes: up_q masks the factory load edge after reset
`timescale 1ns/1ps
`default_nettype none
module oct_sva import oct_pkg::*; (
	// Clock and inputs
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire oct_req_t req_i,
	input wire oct_cal_t cal_i,
	input wire oct_sel_t sel_i,
	// Outputs
	input wire logic [DATA_W-1:0] rd_data_o,
	input wire logic [TRIM_W-1:0] core_c_offset_o,
	input wire logic [TRIM_W-1:0] core_b_offset_o,
	input wire logic write_safe_o,
	input wire logic read_safe_o
);
	logic up_q;
	// High once the load edge has passed; a write there is lost by design
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			up_q <= 1'b0;
		else
			up_q <= 1'b1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	property p_rd_idle; $past(ce_i) && !$past(req_i.rd) |-> rd_data_o == RDATA_IDLE; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
	property p_unmapped; ce_i && req_i.rd && (req_i.addr < 12'h08e || req_i.addr > 12'h095) |=> rd_data_o == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_wr_rd; logic [11:0] a; logic [7:0] d;
		(up_q && ce_i && req_i.wr && req_i.addr >= 12'h08e && req_i.addr <= 12'h095, a = req_i.addr, d = req_i.wdata)
		##1 (ce_i && req_i.rd && req_i.addr == a) |=> rd_data_o == d; endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("read back differs from write");
	property p_c_hold; (up_q && ce_i && $stable(sel_i) && !(req_i.wr && req_i.addr <= 12'h091))[*2]
		|=> $stable(core_c_offset_o); endproperty
	a_c_hold: assert property (p_c_hold) else $error("core C offset moved");
	property p_b_hold; (up_q && ce_i && $stable(sel_i) && !(req_i.wr && req_i.addr >= 12'h092))[*2]
		|=> $stable(core_b_offset_o); endproperty
	a_b_hold: assert property (p_b_hold) else $error("core B offset moved");
	property p_c_follow; logic [7:0] d; (up_q && ce_i && req_i.wr && req_i.addr == 12'h08e && !sel_i.core_c_on_b,
		d = req_i.wdata) ##1 (ce_i && !req_i.wr && !sel_i.core_c_on_b) |=> core_c_offset_o[7:0] == d; endproperty
	a_c_follow: assert property (p_c_follow) else $error("core C offset not updated");
	property p_wsafe; $past(up_q) && $past(ce_i) |-> write_safe_o == !($past(cal_i.fg_running) ||
		$past(cal_i.background_cal_enable && cal_i.background_offset_cal_enable)); endproperty
	a_wsafe: assert property (p_wsafe) else $error("write advice wrong");
	property p_rsafe; $past(up_q) && $past(ce_i) |-> read_safe_o == $past(cal_i.offset_cal_enable &&
		!cal_i.background_offset_cal_enable ? cal_i.foreground_cal_done : cal_i.background_cal_enable &&
		cal_i.background_offset_cal_enable ? cal_i.cal_halted_flag : 1'b1); endproperty
	a_rsafe: assert property (p_rsafe) else $error("read advice wrong");
endmodule
bind oct_offset_trim_bank oct_sva i_sva (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .req_i(req_i),
	.cal_i(cal_i), .sel_i(sel_i), .rd_data_o(rd_data_o), .core_c_offset_o(core_c_offset_o),
	.core_b_offset_o(core_b_offset_o), .write_safe_o(write_safe_o), .read_safe_o(read_safe_o));
`default_nettype wire

// [testbench/testbench.sv]
// Purpose: Self-checking bench for the offset trim bank
// Assumes: ce_i high except in the freeze scenario, factory trims fixed
// Notes: exp_q tracks the expected trim words
`timescale 1ns/1ps
`default_nettype none
module testbench import oct_pkg::*;;
	localparam logic [47:0] FT = 48'h9ab6_7834_5012;
	logic clk_i, arst_n_i, ce, ws, rs;
	oct_req_t req;
	oct_cal_t cal;
	oct_sel_t sel;
	logic [7:0] rd_data;
	logic [11:0] c_ofs, b_ofs;
	logic [15:0] exp_q [4];
	int failures, num_checks;
	oct_offset_trim_bank i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .req_i(req), .rd_data_o(rd_data),
		.factory_trim_i(FT), .cal_i(cal), .sel_i(sel), .core_c_offset_o(c_ofs), .core_b_offset_o(b_ofs),
		.write_safe_o(ws), .read_safe_o(rs));
	// Clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wrap_up;
		if (failures == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Read strobe, data judged in the slot after it
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk_i);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk_i);
		req.rd <= 1'b0;
		#1 chk({8'h00, rd_data}, {8'h00, e});
	endtask
	// Write followed at once by a read of the same byte; strobes never overlap
	task automatic wr_rd(input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
		@(posedge clk_i);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk_i);
		req.wr <= 1'b0;
		req.rd <= 1'b1;
		@(posedge clk_i);
		req.rd <= 1'b0;
		#1 chk({8'h00, rd_data}, {8'h00, e});
	endtask
	task automatic t_reset_vals;
		for (int k = 0; k < 8; k++) rd(12'h08e + 12'(k), exp_q[k/2][8*(k%2) +: 8]);
	endtask
	task automatic t_write_back;
		logic [7:0] d;
		@(posedge clk_i);
		sel <= '0;
		for (int k = 0; k < 8; k++) begin
			d = 8'h5a + 8'(37 * k);
			wr_rd(12'h08e + 12'(k), d, d);
			exp_q[k/2][8*(k%2) +: 8] = d;
		end
		wr_rd(12'h08d, 8'hff, 8'h00);
		wr_rd(12'h096, 8'hff, 8'h00);
	endtask
	task automatic t_offsets;
		for (int s = 0; s < 4; s++) begin
			@(posedge clk_i);
			sel <= oct_sel_t'(s[1:0]);
			repeat (2) @(posedge clk_i);
			#1 chk({4'h0, c_ofs}, {4'h0, exp_q[s[1] ? 1 : 0][11:0]});
			chk({4'h0, b_ofs}, {4'h0, exp_q[s[0] ? 3 : 2][11:0]});
		end
	endtask
	task automatic t_flags;
		oct_cal_t c;
		logic we, re;
		for (int i = 0; i < 64; i++) begin
			c = oct_cal_t'(i[5:0]);
			we = !(c.fg_running || (c.background_cal_enable && c.background_offset_cal_enable));
			re = (c.offset_cal_enable && !c.background_offset_cal_enable) ? c.foreground_cal_done :
				(c.background_cal_enable && c.background_offset_cal_enable) ? c.cal_halted_flag : 1'b1;
			@(posedge clk_i);
			cal <= c;
			repeat (2) @(posedge clk_i);
			#1 chk({15'h0, ws}, {15'h0, we});
			chk({15'h0, rs}, {15'h0, re});
		end
	endtask
	// Clock enable low: writes and output updates are held off
	task automatic t_freeze;
		@(posedge clk_i);
		ce <= 1'b0;
		sel <= '0;
		req.addr <= 12'h08e;
		req.wdata <= ~exp_q[0][7:0];
		req.wr <= 1'b1;
		@(posedge clk_i);
		req.wr <= 1'b0;
		@(posedge clk_i);
		#1 chk({4'h0, c_ofs}, {4'h0, exp_q[1][11:0]});
		@(posedge clk_i);
		ce <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1 chk({4'h0, c_ofs}, {4'h0, exp_q[0][11:0]});
		chk({4'h0, b_ofs}, {4'h0, exp_q[2][11:0]});
		rd(12'h08e, exp_q[0][7:0]);
	endtask
	// Main sequence; reset held for eight cycles
	initial begin
		arst_n_i = 1'b0;
		ce = 1'b1;
		req = '0;
		cal = '0;
		sel = '0;
		failures = 0;
		num_checks = 0;
		for (int k = 0; k < 4; k++) exp_q[k] = {4'h0, FT[12*k +: 12]};
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		t_reset_vals();
		t_offsets();
		t_write_back();
		t_offsets();
		t_freeze();
		t_flags();
		wrap_up();
	end
	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		wrap_up();
	end
endmodule
`default_nettype wire
